/* inc/slot_sched_pkg.sv */
// Package: constants and carrier types for the bus frame slot scheduler
`default_nettype none
package slot_sched_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned MINOR_PERIOD_US = 8000;
  localparam int unsigned MINOR_TOL_US = 100;
  localparam int unsigned MINOR_CYCLES = MINOR_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TOL_CYCLES = MINOR_TOL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned MINORS_PER_MAJOR = 128;
  localparam int unsigned MAJORS_PER_MASTER = 64;
  localparam logic [4:0] RT_ADDR = 5'h0c;
  localparam logic [4:0] MODE_SYNC_DATA = 5'h11;
  localparam logic [4:0] SUBADDR_MODE_LO = 5'h00;
  localparam logic [4:0] SUBADDR_MODE_HI = 5'h1f;
  localparam logic [6:0] SYNC_SLOT_0 = 7'h0c;
  localparam logic [1:0] SYNC_SLOT_MASK = 2'h3;

  // Decoded command word from the bus receiver
  typedef struct packed {
    logic [4:0] rt_addr;
    logic tx;
    logic [4:0] subaddr;
    logic [4:0] count;
  } cmd_word_s;

  // Cycle position seen by the terminal
  typedef struct packed {
    logic [5:0] major;
    logic [6:0] minor;
    logic tick;
  } cycle_pos_s;
endpackage : slot_sched_pkg
`default_nettype wire

/* design/minor_timer.sv */
// Free-running minor cycle timer with restart
`default_nettype none
module minor_timer #(
  parameter int unsigned PERIOD = slot_sched_pkg::MINOR_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control
  input wire logic restart,
  // Status
  output logic tick
);
  localparam int W = $clog2(PERIOD);
  initial
  begin
    if (PERIOD < 2) $error("minor_timer: PERIOD too small");
  end
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } st_s;
  st_s st_q, st_d;
  // Start at one so the first tick lands a full period after reset
  localparam st_s RST_ST = '{cnt: W'(1), tick: 1'b0};
  always_comb
  begin
    st_d = st_q;
    st_d.tick = 1'b0;
    // Load one, not zero: the caller's position changes on this same edge
    if (restart)
      st_d.cnt = W'(1);
    else if (st_q.cnt == W'(PERIOD - 1))
    begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end
    else
      st_d.cnt = st_q.cnt + W'(1);
  end
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      st_q <= RST_ST;
    else
      st_q <= st_d;
  end
  assign tick = st_q.tick;
endmodule : minor_timer
`default_nettype wire

/* design/slot_scheduler.sv */
// Remote terminal minor/major cycle tracker and slot flags
`default_nettype none
module slot_scheduler #(
  parameter int unsigned MINOR_PERIOD = slot_sched_pkg::MINOR_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Decoded bus command, valid one cycle
  input wire logic cmd_valid,
  input wire slot_sched_pkg::cmd_word_s cmd,
  input wire logic data_valid,
  input wire logic [15:0] data_word,
  // Position and events
  output slot_sched_pkg::cycle_pos_s pos,
  output logic addressed,
  output logic sync_seen,
  output logic [15:0] sync_data,
  output logic ground_slot,
  output logic sync_missed
);

  // Refuse a period the tick counter cannot serve
  if (MINOR_PERIOD < 2)
  begin : g_bad_period
    $error("slot_scheduler: MINOR_PERIOD below 2");
  end

  // Whole state of the tracker
  typedef struct packed {
    logic [6:0] minor;
    logic [5:0] major;
    logic tick;
    logic addressed;
    logic wait_data;
    logic sync_seen;
    logic got_sync;
    logic [15:0] sync_data;
    logic missed;
  } st_s;

  st_s st_q;
  st_s st_d;

  // Timer and decode
  logic tick;
  logic restart;
  logic is_mine;
  logic is_mode_sa;
  logic is_sync;
  logic accept;
  logic step;
  logic sync_slot;
  // Position arithmetic
  logic minor_last;
  logic major_last;
  logic [6:0] minor_inc;
  logic [5:0] major_inc;

  // Restart as the data word is taken, so the next tick falls a full
  // period after the realigned position shows
  assign restart = accept;

  minor_timer #(
    .PERIOD(MINOR_PERIOD)
  ) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(restart),
    .tick(tick)
  );

  // Flag commands for this terminal; commands for others only void a pending sync
  always_comb
  begin
    if (cmd_valid && (cmd.rt_addr == slot_sched_pkg::RT_ADDR))
    begin
      is_mine = 1'b1;
    end
    else
    begin
      is_mine = 1'b0;
    end
  end

  // Mode codes may come on either mode subaddress
  always_comb
  begin
    if (cmd.subaddr == slot_sched_pkg::SUBADDR_MODE_LO)
    begin
      is_mode_sa = 1'b1;
    end
    else if (cmd.subaddr == slot_sched_pkg::SUBADDR_MODE_HI)
    begin
      is_mode_sa = 1'b1;
    end
    else
    begin
      is_mode_sa = 1'b0;
    end
  end

  // Synchronize with data word: receive direction, one mode code
  always_comb
  begin
    is_sync = 1'b0;
    if (is_mine && !cmd.tx && is_mode_sa)
    begin
      if (cmd.count == slot_sched_pkg::MODE_SYNC_DATA)
      begin
        is_sync = 1'b1;
      end
    end
  end

  // Data word counts only after our sync command, before any other command
  assign accept = data_valid && st_q.wait_data && !is_sync;

  // A tick that meets a realign is dropped: the new position wins
  always_comb
  begin
    if (tick && !accept)
    begin
      step = 1'b1;
    end
    else
    begin
      step = 1'b0;
    end
  end

  // Expected sync minors 12,44,76,108: low five bits equal 12
  assign sync_slot = (st_q.minor[4:0] == slot_sched_pkg::SYNC_SLOT_0[4:0]);
  assign minor_last = (st_q.minor == 7'(slot_sched_pkg::MINORS_PER_MAJOR - 1));
  assign major_last = (st_q.major == 6'(slot_sched_pkg::MAJORS_PER_MASTER - 1));
  assign minor_inc = st_q.minor + 7'h01;
  assign major_inc = st_q.major + 6'h01;

  // Next state
  always_comb
  begin
    st_d = st_q;
    st_d.tick = step;
    st_d.addressed = is_mine;
    st_d.sync_seen = 1'b0;
    st_d.missed = 1'b0;

    // Handshake with the controller: command, then data word
    if (is_sync)
    begin
      st_d.wait_data = 1'b1;
    end
    else if (accept)
    begin
      st_d.wait_data = 1'b0;
    end
    else if (cmd_valid)
    begin
      // Any other command in between voids the pending sync
      st_d.wait_data = 1'b0;
    end

    // Realign to the controller's position carried in the data word
    if (accept)
    begin
      st_d.sync_data = data_word;
      st_d.sync_seen = 1'b1;
      st_d.got_sync = 1'b1;
      st_d.minor = data_word[6:0];
      st_d.major = data_word[12:7];
    end

    // Close the minor just ended: a sync slot without sync is an error
    if (step)
    begin
      if (sync_slot && !st_q.got_sync)
      begin
        st_d.missed = 1'b1;
      end
      st_d.got_sync = 1'b0;
      if (minor_last)
      begin
        st_d.minor = '0;
        if (major_last)
        begin
          st_d.major = '0;
        end
        else
        begin
          st_d.major = major_inc;
        end
      end
      else
      begin
        st_d.minor = minor_inc;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Registered outputs straight from the state
  assign pos.major = st_q.major;
  assign pos.minor = st_q.minor;
  assign pos.tick = st_q.tick;
  assign addressed = st_q.addressed;
  assign sync_seen = st_q.sync_seen;
  assign sync_data = st_q.sync_data;
  assign sync_missed = st_q.missed;
  // Ground commands land only on minors that are multiples of four
  assign ground_slot = ((st_q.minor[1:0] & slot_sched_pkg::SYNC_SLOT_MASK) == 2'h0);
endmodule : slot_scheduler
`default_nettype wire

/* test/bus_ctrl_model.sv */
// Bus controller model that sends synchronize messages
`default_nettype none
module bus_ctrl_model (
  input wire logic clk_sys,
  output var logic cmd_valid,
  output var logic data_valid,
  output var slot_sched_pkg::cmd_word_s cmd,
  output var logic [15:0] data_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cmd_valid, data_valid, cmd, data_word} = '0;
  // Only sync traffic: no onboard, ground, dump or loop-back messages
  // One synchronize a call, its command before its data word
  task automatic send_sync(input logic [4:0] rt, input logic [15:0] w);
    @(negedge clk_sys);
    cmd = {rt, 1'b0, 5'h00, slot_sched_pkg::MODE_SYNC_DATA};
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    // Released lines must not keep showing the last value
    cmd = ~cmd;
    data_word = w;
    data_valid = 1'b1;
    @(negedge clk_sys);
    data_valid = 1'b0;
    data_word = ~w;
  endtask : send_sync
endmodule : bus_ctrl_model
`default_nettype wire

/* test/slot_scheduler_asserts.sv */
// Port checker for the slot scheduler
`default_nettype none
module slot_scheduler_asserts #(parameter int P = 50) (
  input wire logic clk_sys, rstn, cmd_valid, data_valid, addressed, sync_seen, sync_missed,
  input wire slot_sched_pkg::cmd_word_s cmd,
  input wire logic [15:0] data_word, sync_data,
  input wire slot_sched_pkg::cycle_pos_s pos
);
  int c_q;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      c_q <= 0;
    else
      c_q <= (pos.tick || sync_seen) ? 0 : c_q + 1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_tick_overdue: assert property (c_q <= P) else $error("minor tick overdue");
  a_tick_early: assert property (pos.tick |-> c_q >= P - 3) else $error("tick early");
  a_minor_step: assert property (pos.tick && !sync_seen |->
    pos.minor == $past(pos.minor) + 7'h01) else $error("minor step wrong");
  a_major_step: assert property (pos.tick && !sync_seen && $past(pos.minor) == 7'h7f |->
    pos.major == $past(pos.major) + 6'h01) else $error("major step wrong");
  a_addr_match: assert property (addressed ==
    ($past(cmd_valid) && $past(cmd.rt_addr) == slot_sched_pkg::RT_ADDR)) else $error("addr");
  a_sync_word: assert property (sync_seen |->
    $past(data_valid) && sync_data == $past(data_word)) else $error("sync word");
  a_pos_realign: assert property (sync_seen |->
    pos[13:1] == $past(data_word[12:0])) else $error("no realign");
  a_miss_place: assert property (sync_missed |->
    pos.minor[4:0] inside {5'h0c, 5'h0d}) else $error("miss misplaced");
  c_sync: cover property (sync_seen);
  c_miss: cover property (sync_missed);
  c_wrap: cover property (pos.tick && pos.minor == 7'h00);
endmodule : slot_scheduler_asserts
bind slot_scheduler slot_scheduler_asserts #(.P(MINOR_PERIOD)) u_chk (.*);
`default_nettype wire

/* test/bus_frame_slot_scheduler_tb.sv */
// Testbench for the slot scheduler
`default_nettype none
module bus_frame_slot_scheduler_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 50;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid, data_valid, addressed, sync_seen, ground_slot, sync_missed;
  slot_sched_pkg::cmd_word_s cmd;
  logic [15:0] data_word, sync_data;
  slot_sched_pkg::cycle_pos_s pos;
  int errors = 0;
  int samples_checked = 0;
  int n_addr = 0;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) n_addr <= n_addr + int'(addressed);
  bus_ctrl_model bc (.*);
  slot_scheduler #(.MINOR_PERIOD(P)) DUT (.*);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic t_sync(input logic [4:0] rt, input logic [15:0] w);
    int a;
    logic hit;
    a = n_addr;
    hit = (rt == slot_sched_pkg::RT_ADDR);
    bc.send_sync(rt, w);
    check(16'(n_addr - a), 16'(hit));
    check(16'(sync_seen), 16'(hit));
    if (hit)
    begin
      check({3'h0, pos.major, pos.minor}, w);
      check(sync_data, w);
      check(16'(ground_slot), 16'(w[1:0] == 2'h0));
    end
  endtask : t_sync
  task automatic wait_for(input logic use_miss, output int n);
    n = 0;
    while ((use_miss ? sync_missed : pos.tick) !== 1'b1 && n < 3 * P)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_for
  task automatic t_wrap;
    int n;
    t_sync(5'h0c, 16'h1fff);
    wait_for(1'b0, n);
    check(16'(n), 16'(P));
    check({3'h0, pos.major, pos.minor}, 16'h0000);
  endtask : t_wrap
  task automatic t_miss;
    int n;
    // Land one minor before the synchronize slot, then stay silent
    t_sync(5'h0c, 16'h008b);
    wait_for(1'b1, n);
    check(16'(n), 16'(2 * P));
    check(16'(pos.minor), 16'h000d);
  endtask : t_miss
  task automatic t_reset;
    @(negedge clk_sys);
    rstn = 1'b0;
    @(negedge clk_sys);
    check({pos, ground_slot, sync_missed}, 16'h0002);
    check(sync_data, 16'h0000);
    rstn = 1'b1;
    @(negedge clk_sys);
    check({pos, ground_slot, sync_seen}, 16'h0002);
    t_sync(5'h0c, 16'h0484);
  endtask : t_reset
  task automatic results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    t_sync(5'h0c, 16'h02ac);
    t_sync(5'h0d, 16'h0110);
    t_wrap;
    t_miss;
    t_reset;
    results;
  end
  initial
  begin
    #(800 * P);
    errors++;
    results;
  end
endmodule : bus_frame_slot_scheduler_tb
`default_nettype wire
